// ==== bench/spi_eeprom_write_and_id_page_test.sv ====
// self-checking bench for the serial eeprom write and identification page block
`timescale 1ns/1ps
module spi_eeprom_write_and_id_page_test;
   localparam logic [127:0] UID = 128'hA5A5_0000_1111_2222_3333_4444_5555_66C3; // arbitrary
   // pins and bench state
   logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i, b;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic chipSelectN, serialClk, serialIn, serialOut, serialOutEnN;
   int err_total = 0;
   int checks = 0;
   spi_eeprom_core #(.MEM_BYTES(4096), .WR_CYCLES(1000), .UID_VALUE(UID)) dut_u (.ref_clk,
      .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .chipSelectN, .serialClk, .serialIn, .serialOut, .serialOutEnN);
   spi_host_model host_u (.ref_clk, .chipSelectN, .serialClk, .serialOut, .serialOutEnN,
      .serialIn);
   // 40 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // verdict and end of run
   task automatic results();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   // compare one value
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one classic wishbone cycle, read data left in rd; only the watchdog ends a wait
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
      do begin
         @(posedge ref_clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge ref_clk);
      chk("ack drop", 0, {31'h0, wb_ack_o});
   endtask : wb
   // serial helpers
   task automatic tx(input logic [7:0] d);
      host_u.xfer(d, 8, b);
   endtask : tx
   task automatic cmd(input logic [7:0] op, input logic [23:0] a);
      host_u.sel(1'b1);
      tx(op);
      tx(a[23:16]);
      tx(a[15:8]);
      tx(a[7:0]);
   endtask : cmd
   // latch set: instruction alone, then select high
   task automatic set_write_latch_cmd();
      host_u.sel(1'b1);
      tx(8'h06);
      host_u.sel(1'b0);
   endtask : set_write_latch_cmd
   // array write of one byte, closed on a byte boundary
   task automatic try_wr(input logic [23:0] a);
      cmd(8'h02, a);
      tx(8'h5A);
      host_u.sel(1'b0);
   endtask : try_wr
   // lock frame with data bit one set
   task automatic lock();
      cmd(8'h82, 24'h00_0400);
      tx(8'h02);
      host_u.sel(1'b0);
   endtask : lock
   task automatic stat(input logic [31:0] exp);
      wb(1'b0, eeprom_pkg::STAT_OFS, 32'h0);
      chk("stat", exp, rd);
   endtask : stat
   // busy after the select rise, then idle with the latch cleared
   task automatic busy_run();
      int n;
      n = 0;
      wb(1'b0, eeprom_pkg::STAT_OFS, 32'h0);
      chk("busy", 1, rd[0]);
      do wb(1'b0, eeprom_pkg::STAT_OFS, 32'h0); while (rd[0] !== 1'b0 && ++n < 500);
      chk("idle", 0, rd[1:0]);
   endtask : busy_run
   task automatic peek(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b1, eeprom_pkg::PEEK_ADDR_OFS, {24'h0, a});
      wb(1'b0, eeprom_pkg::PEEK_DATA_OFS, 32'h0);
      chk("peek", exp, rd);
   endtask : peek
   task automatic rdbyte(input logic [7:0] exp);
      tx(8'h00);
      chk("serial", {24'h0, exp}, {24'h0, b});
   endtask : rdbyte
   // reset values and an unmapped read
   task automatic t_reset();
      stat(32'h0);
      wb(1'b0, 8'hF7, 32'h0);
      chk("unmapped", 0, rd);
   endtask : t_reset
   // refused writes: no latch, misaligned select rise, protected page
   task automatic t_refuse();
      try_wr(24'h00_0010);
      stat(32'h0);
      set_write_latch_cmd();
      cmd(8'h02, 24'h00_0010);
      host_u.xfer(8'h5A, 7, b);
      host_u.sel(1'b0);
      stat(32'h2);
      wb(1'b1, eeprom_pkg::CTRL_OFS, 32'h3);
      try_wr(24'h00_0010);
      stat(32'h2);
      // byte lane zero alone carries the protect field
      wb_sel_i <= 4'h1;
      wb(1'b1, eeprom_pkg::CTRL_OFS, 32'hFFFF_FFFE);
      wb_sel_i <= 4'hE;
      wb(1'b1, eeprom_pkg::CTRL_OFS, 32'h1);
      wb_sel_i <= 4'hF;
      wb(1'b0, eeprom_pkg::CTRL_OFS, 32'h0);
      chk("ctrl", 2, rd);
      try_wr(24'h00_0800);
      stat(32'h2);
      wb(1'b1, eeprom_pkg::CTRL_OFS, 32'h1);
      try_wr(24'h00_0C00);
      stat(32'h2);
      wb(1'b1, eeprom_pkg::CTRL_OFS, 32'h0);
      peek(8'h10, 32'hFF);
   endtask : t_refuse
   // page write with roll-over, a read ignored while busy, then correction
   task automatic t_page();
      cmd(8'h02, 24'h00_00FE);
      tx(8'hA1);
      tx(8'hA2);
      tx(8'hA3);
      host_u.sel(1'b0);
      cmd(8'h83, 24'h00_0005);
      tx(8'h00);
      chk("out enable", 1, serialOutEnN);
      host_u.sel(1'b0);
      busy_run();
      peek(8'hFE, 32'hA1);
      peek(8'hFF, 32'hA2);
      peek(8'h00, 32'hA3);
      peek(8'hFC, 32'hFF);
      wb(1'b1, eeprom_pkg::INJECT_OFS, 32'd17);
      peek(8'hFE, 32'h1A1);
   endtask : t_page
   // id page write, lock status, lock, then refused write on the locked page
   task automatic t_id();
      set_write_latch_cmd();
      cmd(8'h82, 24'h00_0005);
      tx(8'h3C);
      host_u.sel(1'b0);
      busy_run();
      cmd(8'h83, 24'h00_0005);
      rdbyte(8'h3C);
      rdbyte(8'hFF);
      host_u.sel(1'b0);
      cmd(8'h83, 24'h00_0400);
      rdbyte(8'h00);
      host_u.sel(1'b0);
      lock();
      stat(32'h0);
      wb(1'b1, eeprom_pkg::CTRL_OFS, 32'h3);
      set_write_latch_cmd();
      lock();
      stat(32'h2);
      wb(1'b1, eeprom_pkg::CTRL_OFS, 32'h0);
      lock();
      busy_run();
      cmd(8'h83, 24'h00_0400);
      rdbyte(8'h01);
      rdbyte(8'h01);
      host_u.sel(1'b0);
      set_write_latch_cmd();
      cmd(8'h82, 24'h00_0005);
      tx(8'h00);
      host_u.sel(1'b0);
      stat(32'h6);
      cmd(8'h83, 24'h00_000F);
      rdbyte(8'hFF);
      host_u.sel(1'b0);
   endtask : t_id
   // unique number wraps within its sixteen bytes
   task automatic t_uid();
      cmd(8'h83, 24'h00_020F);
      rdbyte(UID[127:120]);
      rdbyte(UID[7:0]);
      host_u.sel(1'b0);
   endtask : t_uid
   // main sequence
   initial begin
      {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= '0;
      wb_sel_i <= 4'hF;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_reset();
      t_refuse();
      t_page();
      t_id();
      t_uid();
      results();
   end
   // watchdog against a hang
   initial begin
      repeat (60000) @(posedge ref_clk);
      err_total++;
      results();
   end
endmodule : spi_eeprom_write_and_id_page_test

// ==== bench/spi_host_model.sv ====
// serial host model that drives select, clock and data into the eeprom block
`timescale 1ns/1ps
module spi_host_model (
   // timing reference
   input wire logic ref_clk,
   // serial pins
   output logic chipSelectN,
   output logic serialClk,
   input wire logic serialOut,
   input wire logic serialOutEnN,
   output logic serialIn
);
   // deselected, clock parked low between frames
   initial begin
      chipSelectN = 1'b1;
      serialClk = 1'b0;
      serialIn = 1'b0;
   end
   // wait a number of reference edges
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : tick
   // select or deselect with the clock idle; data line toggles as it is released
   task automatic sel(input logic on);
      tick(4);
      chipSelectN <= ~on;
      serialIn <= ~serialIn;
      tick(4);
   endtask : sel
   // shift bits msb first, sample the reply just before each falling edge;
   // an undriven output line reads as the inverse of its last value
   task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         serialIn <= tx[i];
         tick(4);
         serialClk <= 1'b1;
         tick(4);
         rx[i] = serialOutEnN ? ~serialOut : serialOut;
         serialClk <= 1'b0;
      end
   endtask : xfer
endmodule : spi_host_model

// ==== logic/eeprom_pkg.sv ====
// constants shared by the serial eeprom write and identification page block
package eeprom_pkg;
   // wishbone register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] PEEK_ADDR_OFS = 8'h08;
   localparam logic [7:0] PEEK_DATA_OFS = 8'h0C;
   localparam logic [7:0] INJECT_OFS = 8'h10;
   // reset values
   localparam logic [1:0] BP_RST = 2'h0;
   // serial instruction codes
   localparam logic [7:0] OP_SET_WRITE_LATCH_CMD = 8'h06;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_RD_ID = 8'h83;
   localparam logic [7:0] OP_WR_ID = 8'h82;
   // address bit positions that pick the side space
   localparam int ID_SEL_POS = 10;
   localparam int UID_SEL_POS = 9;
   // lock data byte bit that must be one
   localparam int LOCK_DATA_POS = 1;
   // sizes of the side spaces
   localparam int ID_PAGE_BYTES = 128;
   localparam int UID_BYTES = 16;
   // self-timed write duration and the cycle count it takes
   localparam int WRITE_TIME_NS = 5000000;
   localparam int CLK_PERIOD_NS = 25;
   localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
   // write targets
   localparam logic [1:0] TGT_ARR = 2'h0;
   localparam logic [1:0] TGT_ID = 2'h1;
   localparam logic [1:0] TGT_LOCK = 2'h2;
   // read kinds
   localparam logic [1:0] RD_ID = 2'h0;
   localparam logic [1:0] RD_LOCK = 2'h1;
   localparam logic [1:0] RD_UID = 2'h2;
   // serial frame states
   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_CMD = 6'h02,
      S_ADDR = 6'h04,
      S_WDATA = 6'h08,
      S_RDATA = 6'h10,
      S_SKIP = 6'h20
   } spi_state_e;
endpackage : eeprom_pkg

// ==== logic/spi_eeprom_core.sv ====
// serial eeprom write path, identification page, lock and unique number
`timescale 1ns/1ps
module spi_eeprom_core #(
   parameter int MEM_BYTES = 131072, // array size in bytes
   parameter int PAGE_BYTES = 256, // write page size
   parameter int WR_CYCLES = eeprom_pkg::WRITE_CYCLES, // self-timed write length
   parameter logic [127:0] UID_VALUE = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978 // arbitrary
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial link pins
   input wire logic chipSelectN,
   input wire logic serialClk,
   input wire logic serialIn,
   output logic serialOut,
   output logic serialOutEnN
);
   localparam int AW = $clog2(MEM_BYTES);
   localparam int PW = $clog2(PAGE_BYTES);
   localparam int GW = PW - 2;
   localparam int IW = $clog2(eeprom_pkg::ID_PAGE_BYTES);

   // refuse sizes the logic cannot serve
   if (MEM_BYTES != (1 << AW) || PAGE_BYTES != (1 << PW) || PW < IW || AW - PW < 2
       || AW > 24 || WR_CYCLES < PAGE_BYTES + 4) begin : g_badParams
      $error("unsupported eeprom parameters");
   end

   // page buffer: data bytes of the open frame
   logic [7:0] pageBuf [PAGE_BYTES];

   // hamming position of data bit i, powers of two left to check bits
   function automatic logic [5:0] eccPos(input int i);
      logic [5:0] p;
      p = 6'h02;
      for (int k = 0; k <= i; k++) begin
         p = p + 6'h01;
         if ((p & (p - 6'h01)) == 6'h00) p = p + 6'h01;
      end
      return p;
   endfunction : eccPos

   // check bits of a data word
   function automatic logic [5:0] eccChk(input logic [31:0] d);
      logic [5:0] s;
      s = 6'h00;
      for (int i = 0; i < 32; i++) if (d[i]) s = s ^ eccPos(i);
      return s;
   endfunction : eccChk

   // stored word with one flipped data bit put right
   function automatic logic [31:0] eccFix(input logic [37:0] w);
      logic [5:0] syn;
      logic [31:0] d;
      d = w[31:0];
      syn = eccChk(d) ^ w[37:32];
      for (int i = 0; i < 32; i++) if (eccPos(i) == syn) d[i] = ~d[i];
      return d;
   endfunction : eccFix

   // byte lane of a word
   function automatic logic [7:0] byteOf(input logic [31:0] d, input logic [1:0] s);
      return d[8*s +: 8];
   endfunction : byteOf

   // storage starts erased, check bits above the data word; a declaration value
   // keeps the write port the only process that writes the arrays
   localparam logic [37:0] ERASED = {eccChk(32'hFFFF_FFFF), 32'hFFFF_FFFF};
   logic [37:0] mem [MEM_BYTES/4] = '{default: ERASED};
   logic [37:0] idMem [eeprom_pkg::ID_PAGE_BYTES/4] = '{default: ERASED};

   logic [2:0] csSync_q; // select synchroniser and edge history
   logic [2:0] sckSync_q; // serial clock synchroniser and edge history
   logic [1:0] mosiSync_q; // data synchroniser
   eeprom_pkg::spi_state_e state_q; // frame state
   logic [2:0] bitCnt_q; // bits of the current byte
   logic [7:0] shift_q; // incoming bits
   logic [7:0] op_q; // instruction of the frame
   logic [23:0] addr_q; // address bytes as received
   logic [1:0] addrCnt_q; // address bytes seen
   logic [PW-1:0] wrPtr_q; // in-page write offset
   logic [AW-PW-1:0] page_q; // write page number
   logic gotData_q; // at least one data byte in
   logic lockBit_q; // first data byte bit one
   logic [6:0] rdPtr_q; // side space read offset
   logic [1:0] rdKind_q; // which side space is read
   logic [PAGE_BYTES-1:0] mask_q; // page buffer bytes to commit
   logic busy_q; // write_busy_flag
   logic wel_q; // write_enable_latch
   logic lock_q; // id page lock
   logic [31:0] wrCnt_q; // cycles left of the timed write
   logic [1:0] tgt_q; // what the timed write commits
   logic [GW:0] wIdx_q; // word walked by the commit
   logic phase_q; // low: erase step, high: program step
   logic [31:0] merge_q; // group content to program
   logic [1:0] bp_q; // block_protect_hi, block_protect_lo
   logic [AW-1:0] peek_q; // array byte shown to software
   logic [31:0] wbDat_q; // read data
   logic ack_q; // wishbone ack
   logic out_q; // serial output bit
   logic oeN_q; // serial output enable, low drives

   // link edges, seen only from the second synchroniser stage on
   logic csLow, csRise, csFall, sckRise, sckFall, bitIn, byteDone;
   logic [7:0] rxByte;
   logic [23:0] newAddr;
   assign csLow = !csSync_q[1];
   assign csRise = csSync_q[1] & !csSync_q[2];
   assign csFall = !csSync_q[1] & csSync_q[2];
   assign sckRise = csLow & sckSync_q[1] & !sckSync_q[2];
   assign sckFall = csLow & !sckSync_q[1] & sckSync_q[2];
   assign bitIn = mosiSync_q[1];
   assign rxByte = {shift_q[6:0], bitIn};
   assign byteDone = sckRise && bitCnt_q == 3'h7;
   assign newAddr = {addr_q[15:0], rxByte};

   // instruction decode
   logic opKnown, isWrOp, isIdWr, pbWe;
   logic [PW-1:0] nextPtr;
   assign opKnown = rxByte == eeprom_pkg::OP_WRITE || rxByte == eeprom_pkg::OP_RD_ID
                    || rxByte == eeprom_pkg::OP_WR_ID;
   assign isWrOp = op_q != eeprom_pkg::OP_RD_ID;
   assign isIdWr = op_q == eeprom_pkg::OP_WR_ID && !addr_q[eeprom_pkg::ID_SEL_POS];
   assign nextPtr = isIdWr ? PW'(wrPtr_q[IW-1:0] + IW'(1)) : wrPtr_q + PW'(1);
   assign pbWe = byteDone && state_q == eeprom_pkg::S_WDATA;

   // acceptance at the select rise
   logic aligned, protHit, startArr, startId, startLock, startAny, setWel, endCycle;
   logic [1:0] top2, startTgt;
   assign top2 = page_q[AW-PW-1 -: 2];
   assign protHit = bp_q == 2'h3 || (bp_q == 2'h2 && top2[1])
                    || (bp_q == 2'h1 && top2 == 2'h3);
   assign aligned = state_q == eeprom_pkg::S_WDATA && bitCnt_q == 3'h0 && gotData_q;
   assign startArr = csRise && aligned && op_q == eeprom_pkg::OP_WRITE
                     && wel_q && !protHit;
   assign startId = csRise && aligned && isIdWr && wel_q && !lock_q;
   assign startLock = csRise && aligned && op_q == eeprom_pkg::OP_WR_ID
                      && addr_q[eeprom_pkg::ID_SEL_POS] && wel_q && bp_q != 2'h3
                      && lockBit_q;
   assign startAny = startArr || startId || startLock;
   assign startTgt = startArr ? eeprom_pkg::TGT_ARR :
                     startId ? eeprom_pkg::TGT_ID : eeprom_pkg::TGT_LOCK;
   assign setWel = csRise && state_q == eeprom_pkg::S_SKIP && op_q == eeprom_pkg::OP_SET_WRITE_LATCH_CMD
                   && bitCnt_q == 3'h0 && !busy_q;
   assign endCycle = busy_q && wrCnt_q == 32'h0;

   // synchronisers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         csSync_q <= 3'h7;
         sckSync_q <= 3'h0;
         mosiSync_q <= 2'h0;
      end else begin
         csSync_q <= {csSync_q[1:0], chipSelectN};
         sckSync_q <= {sckSync_q[1:0], serialClk};
         mosiSync_q <= {mosiSync_q[0], serialIn};
      end
   end

   // frame state machine: instruction, address, data bytes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= eeprom_pkg::S_IDLE;
         bitCnt_q <= 3'h0;
         shift_q <= 8'h00;
         op_q <= 8'h00;
         addr_q <= 24'h00_0000;
         addrCnt_q <= 2'h0;
         wrPtr_q <= '0;
         page_q <= '0;
         gotData_q <= 1'b0;
         lockBit_q <= 1'b0;
         rdPtr_q <= 7'h00;
         rdKind_q <= eeprom_pkg::RD_ID;
      end else if (csFall) begin
         state_q <= eeprom_pkg::S_CMD;
         bitCnt_q <= 3'h0;
         addrCnt_q <= 2'h0;
         gotData_q <= 1'b0;
      end else if (!csLow) begin
         state_q <= eeprom_pkg::S_IDLE;
      end else if (sckRise) begin
         shift_q <= rxByte;
         bitCnt_q <= bitCnt_q + 3'h1;
         if (byteDone) begin
            case (state_q)
               eeprom_pkg::S_CMD: begin
                  op_q <= rxByte;
                  // busy: every instruction is ignored to the frame end
                  if (busy_q || !opKnown) begin
                     state_q <= eeprom_pkg::S_SKIP;
                  end else begin
                     state_q <= eeprom_pkg::S_ADDR;
                  end
                  if (rxByte == eeprom_pkg::OP_SET_WRITE_LATCH_CMD) state_q <= eeprom_pkg::S_SKIP;
               end
               eeprom_pkg::S_ADDR: begin
                  addr_q <= newAddr;
                  addrCnt_q <= addrCnt_q + 2'h1;
                  if (addrCnt_q == 2'h2) begin
                     state_q <= isWrOp ? eeprom_pkg::S_WDATA : eeprom_pkg::S_RDATA;
                     page_q <= newAddr[AW-1:PW];
                     wrPtr_q <= (op_q == eeprom_pkg::OP_WR_ID) ? PW'(newAddr[IW-1:0]) :
                                newAddr[PW-1:0];
                     rdPtr_q <= newAddr[6:0];
                     if (newAddr[eeprom_pkg::ID_SEL_POS]) begin
                        rdKind_q <= eeprom_pkg::RD_LOCK;
                     end else if (newAddr[eeprom_pkg::UID_SEL_POS]) begin
                        rdKind_q <= eeprom_pkg::RD_UID;
                     end else begin
                        rdKind_q <= eeprom_pkg::RD_ID;
                     end
                  end
               end
               eeprom_pkg::S_WDATA: begin
                  gotData_q <= 1'b1;
                  if (!gotData_q) lockBit_q <= rxByte[eeprom_pkg::LOCK_DATA_POS];
                  wrPtr_q <= nextPtr;
               end
               eeprom_pkg::S_RDATA: begin
                  rdPtr_q <= rdPtr_q + 7'h01;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // page buffer byte mask, dropped at a new idle frame and after commit
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= '0;
      end else if ((csFall && !busy_q) || endCycle) begin
         mask_q <= '0;
      end else if (pbWe) begin
         mask_q[wrPtr_q] <= 1'b1;
      end
   end

   // commit walk: group content, erased word, programmed word
   logic seqLive, grpHit, seqWe, injectWe, arrWe, idWe;
   logic [37:0] oldWord, seqData, peekWord, arrWData;
   logic [31:0] merged, peekFix;
   logic [AW-3:0] arrWAddr;
   assign seqLive = tgt_q != eeprom_pkg::TGT_LOCK && (tgt_q == eeprom_pkg::TGT_ID ?
                    wIdx_q < (GW+1)'(eeprom_pkg::ID_PAGE_BYTES/4) : !wIdx_q[GW]);
   assign grpHit = |mask_q[{wIdx_q[GW-1:0], 2'h0} +: 4];
   assign oldWord = (tgt_q == eeprom_pkg::TGT_ID) ? idMem[wIdx_q[IW-3:0]] :
                    mem[{page_q, wIdx_q[GW-1:0]}];
   assign seqWe = busy_q && seqLive && (phase_q || grpHit);
   assign seqData = phase_q ? {eccChk(merge_q), merge_q} :
                    {eccChk(32'hFFFF_FFFF), 32'hFFFF_FFFF};
   assign arrWe = (seqWe && tgt_q == eeprom_pkg::TGT_ARR) || injectWe;
   assign idWe = seqWe && tgt_q == eeprom_pkg::TGT_ID;
   assign arrWAddr = injectWe ? peek_q[AW-1:2] : {page_q, wIdx_q[GW-1:0]};
   assign arrWData = injectWe ? peekWord ^ (38'h1 << wb_dat_i[5:0]) : seqData;

   // old group corrected, new bytes laid over it, so all four are rewritten
   always_comb begin
      merged = eccFix(oldWord);
      for (int b = 0; b < 4; b++)
         if (mask_q[{wIdx_q[GW-1:0], 2'(b)}]) merged[8*b +: 8] = pageBuf[{wIdx_q[GW-1:0], 2'(b)}];
   end

   // self-timed write: counter, commit walk, latch and lock update
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         wrCnt_q <= 32'h0;
         tgt_q <= eeprom_pkg::TGT_ARR;
         wIdx_q <= '0;
         phase_q <= 1'b0;
         merge_q <= 32'h0;
         wel_q <= 1'b0;
         lock_q <= 1'b0;
      end else if (startAny) begin
         busy_q <= 1'b1;
         wrCnt_q <= 32'(WR_CYCLES - 1);
         tgt_q <= startTgt;
         wIdx_q <= '0;
         phase_q <= 1'b0;
      end else if (busy_q) begin
         if (endCycle) begin
            busy_q <= 1'b0;
            wel_q <= 1'b0;
            if (tgt_q == eeprom_pkg::TGT_LOCK) lock_q <= 1'b1;
         end else begin
            wrCnt_q <= wrCnt_q - 32'h1;
         end
         if (seqLive && !phase_q && grpHit) begin
            merge_q <= merged;
            phase_q <= 1'b1;
         end else if (seqLive) begin
            phase_q <= 1'b0;
            wIdx_q <= wIdx_q + (GW+1)'(1);
         end
      end else if (setWel) begin
         wel_q <= 1'b1;
      end
   end

   // memory write ports
   always_ff @(posedge ref_clk) begin
      if (arrWe) mem[arrWAddr] <= arrWData;
      if (idWe) idMem[wIdx_q[IW-3:0]] <= seqData;
      if (pbWe) pageBuf[wrPtr_q] <= rxByte;
   end

   // serial output: byte chosen by read kind, shifted on falling edges
   logic [7:0] rdByte;
   assign rdByte = (rdKind_q == eeprom_pkg::RD_LOCK) ? {7'h00, lock_q} :
                   (rdKind_q == eeprom_pkg::RD_UID) ? UID_VALUE[8*rdPtr_q[3:0] +: 8] :
                   byteOf(eccFix(idMem[rdPtr_q[6:2]]), rdPtr_q[1:0]);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_q <= 1'b0;
         oeN_q <= 1'b1;
      end else begin
         oeN_q <= !(csLow && state_q == eeprom_pkg::S_RDATA);
         if (sckFall && state_q == eeprom_pkg::S_RDATA) out_q <= rdByte[3'h7 - bitCnt_q];
      end
   end
   assign serialOut = out_q;
   assign serialOutEnN = oeN_q;

   // wishbone slave: one wait state, unmapped reads zero
   logic wbReq, wbWr;
   logic [31:0] wbRdData;
   assign wbReq = wb_cyc_i && wb_stb_i && !ack_q;
   assign wbWr = wbReq && wb_we_i && wb_sel_i[0];
   assign injectWe = wbWr && wb_adr_i == eeprom_pkg::INJECT_OFS && !busy_q;
   assign peekWord = mem[peek_q[AW-1:2]];
   assign peekFix = eccFix(peekWord);
   assign wbRdData = (wb_adr_i == eeprom_pkg::CTRL_OFS) ? {30'h0, bp_q} :
                     (wb_adr_i == eeprom_pkg::STAT_OFS) ? {29'h0, lock_q, wel_q, busy_q} :
                     (wb_adr_i == eeprom_pkg::PEEK_ADDR_OFS) ? 32'(peek_q) :
                     (wb_adr_i == eeprom_pkg::PEEK_DATA_OFS) ?
                     {23'h0, eccChk(peekWord[31:0]) != peekWord[37:32],
                      byteOf(peekFix, peek_q[1:0])} : 32'h0;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
         wbDat_q <= 32'h0;
         bp_q <= eeprom_pkg::BP_RST;
         peek_q <= '0;
      end else begin
         ack_q <= wbReq;
         if (wbReq) wbDat_q <= wbRdData;
         if (wbWr && wb_adr_i == eeprom_pkg::CTRL_OFS) bp_q <= wb_dat_i[1:0];
         if (wbWr && wb_adr_i == eeprom_pkg::PEEK_ADDR_OFS) peek_q <= wb_dat_i[AW-1:0];
      end
   end
   assign wb_ack_o = ack_q;
   assign wb_dat_o = wbDat_q;

   // checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence sWriteEnd;
      busy_q && wrCnt_q == 32'h0;
   endsequence
   sequence sEraseStep;
      seqWe && !phase_q && seqData[31:0] == 32'hFFFF_FFFF;
   endsequence
   a_busy_min: assert property ($rose(busy_q) |-> busy_q [*8])
      else $error("timed write ended too early");
   a_busy_end: assert property (sWriteEnd |=> !busy_q)
      else $error("busy flag stuck after write");
   a_wel_clear: assert property (sWriteEnd |=> !wel_q)
      else $error("latch not cleared after write");
   a_erase_prog: assert property (sEraseStep |=> seqWe && phase_q)
      else $error("erase not followed by program");
   a_reject_wel: assert property (csRise && aligned && op_q == eeprom_pkg::OP_WRITE
      && !wel_q |=> !busy_q) else $error("write ran without latch");
   a_reject_align: assert property (csRise && state_q == eeprom_pkg::S_WDATA
      && bitCnt_q != 3'h0 |=> !busy_q) else $error("unaligned write ran");
   a_reject_prot: assert property (csRise && op_q == eeprom_pkg::OP_WRITE
      && protHit && !busy_q |=> !busy_q) else $error("protected write ran");
   a_page_wrap: assert property (pbWe && !isIdWr && wrPtr_q == '1
      |=> wrPtr_q == '0) else $error("page pointer did not wrap");
   a_lock_full: assert property (csRise && op_q == eeprom_pkg::OP_WR_ID && bp_q == 2'h3
      && addr_q[eeprom_pkg::ID_SEL_POS] && !busy_q |=> !busy_q)
      else $error("lock ran at full protect");
   a_lock_wel: assert property (csRise && aligned && op_q == eeprom_pkg::OP_WR_ID
      && addr_q[eeprom_pkg::ID_SEL_POS] && !wel_q |=> !busy_q)
      else $error("lock started without latch");
   a_busy_skip: assert property (byteDone && state_q == eeprom_pkg::S_CMD && busy_q
      |=> state_q == eeprom_pkg::S_SKIP) else $error("instruction taken while busy");
   a_end_drive: assert property (csRise |=> serialOutEnN)
      else $error("output still driven after select rise");
endmodule : spi_eeprom_core
